//--- rtl/nbea_encoder.sv
// Error address log encoder with AHB-Lite register access and interrupt
//
// The AHB-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// Summary of operation
// - Default format logs address 47:1, bit0 reserved.
// - Protocol format keeps address 47:6 only when valid.
// - Codes 01,02,03 for unmatched probe/done/start responses.
// - Codes 04,05 for command/data buffer overflow.
// - Code 06 for retry acknowledge counter overflow.
// - Code 07 for data command mid-transfer.
// - Code 08 for bad address-extension follower.
// - Code 09 for coherent-only packet to IO.
// - Code 0A for invalid command outside retry.
// - In retry mode log only CRC-good illegal commands.
// - Code 0B for control drop, retry disabled.
// - Retry enabled: control drop starts retry instead.
// - Codes 10,11 for L3 multiple hits.
// - Code 12 for L3 request queue overflow.
// - Codes 13,14 for incompatible victim states.
// - Layout chosen by error class.
// - Address valid flag marks address as error address.
module nbea_encoder
   import nbea_pkg::*;
(
   // Clock and reset
   input  wire logic              i_clock,
   input  wire logic              i_reset_n,
   // Error event from detectors, same clock domain
   input  wire nbea_pkg::nbea_event_t i_event,
   input  wire logic              i_event_addr_valid,
   input  wire logic [47:0]       i_event_addr,
   input  wire logic              i_event_retry_mode,
   input  wire logic              i_event_crc_ok,
   input  wire logic              i_event_data_pending,
   // Link retry request
   output logic                   o_link_retry,
   // AHB-Lite slave
   input  wire logic              i_hsel,
   input  wire logic [7:0]        i_haddr,
   input  wire logic [1:0]        i_htrans,
   input  wire logic              i_hwrite,
   input  wire logic [2:0]        i_hsize,
   input  wire logic [31:0]       i_hwdata,
   input  wire logic              i_hready,
   output logic [31:0]            o_hrdata,
   output logic                   o_hreadyout,
   output logic                   o_hresp,
   // Interrupt
   output logic                   o_irq
);
   import nbea_pkg::*;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [47:0]           addr_reg;       // error_address_field
   logic                  valid_reg;      // Log holds an error
   logic                  address_valid_flag_reg;      // address_valid_flag
   logic                  prot_reg;       // Protocol format logged
   logic                  retry_en_reg;   // Error-retry mode enable
   logic [NBEA_IRQ_W-1:0] irq_st_reg;     // Sticky events
   logic [NBEA_IRQ_W-1:0] irq_msk_reg;    // Event mask
   logic                  wr_pend_reg;    // Write data phase pending
   logic [7:0]            wr_addr_reg;    // Latched write address

   // ---------------------------------------------------------------
   // Event decode
   // ---------------------------------------------------------------
   logic       ev_is_prot;    // Event uses reason-code format
   logic       ev_log;        // Event gets logged
   logic       ev_retry;      // Event starts a link retry
   logic [4:0] ev_code;       // Reason code

   // Maps an event to its reason code; only listed codes exist
   function automatic logic [4:0] reason_code(input nbea_event_t ev);
      logic [4:0] rc;
      rc = NBEA_RC_RD_RSP;
      unique case (ev)
         NBEA_EV_PROBE_RSP    : rc = NBEA_RC_PROBE_RSP;
         NBEA_EV_TGT_DONE     : rc = NBEA_RC_TGT_DONE;
         NBEA_EV_TGT_START    : rc = NBEA_RC_TGT_START;
         NBEA_EV_CMD_OVF      : rc = NBEA_RC_CMD_OVF;
         NBEA_EV_DATA_OVF     : rc = NBEA_RC_DATA_OVF;
         NBEA_EV_RETRY_OVF    : rc = NBEA_RC_RETRY_OVF;
         NBEA_EV_DATA_MID     : rc = NBEA_RC_DATA_MID;
         NBEA_EV_ADDR_EXT     : rc = NBEA_RC_ADDR_EXT;
         NBEA_EV_COH_TO_IO    : rc = NBEA_RC_COH_TO_IO;
         NBEA_EV_BAD_CMD      : rc = NBEA_RC_BAD_CMD;
         NBEA_EV_CTRL_DROP    : rc = NBEA_RC_CTRL_DROP;
         NBEA_EV_L3_REQ_MULTI : rc = NBEA_RC_L3_REQ;
         NBEA_EV_L3_PRB_MULTI : rc = NBEA_RC_L3_PRB;
         NBEA_EV_L3_RQ_OVF    : rc = NBEA_RC_L3_RQOVF;
         NBEA_EV_L3_WRVIC     : rc = NBEA_RC_L3_WRVIC;
         NBEA_EV_L3_CLVIC     : rc = NBEA_RC_L3_CLVIC;
         default              : rc = NBEA_RC_RD_RSP;
      endcase
      return rc;
   endfunction

   // Classifies the incoming event
   always_comb
   begin
      ev_is_prot = (i_event != NBEA_EV_NONE) && (i_event != NBEA_EV_DEFAULT);
      ev_code    = reason_code(i_event);
      ev_log     = (i_event != NBEA_EV_NONE);
      ev_retry   = 1'b0;
      if (i_event == NBEA_EV_BAD_CMD && i_event_retry_mode && !i_event_crc_ok)
      begin
         // Invalid commands with CRC failures in retry mode are not logged
         ev_log = 1'b0;
      end
      if (i_event == NBEA_EV_CTRL_DROP)
      begin
         if (i_event_data_pending)
         begin
            // Deassertion with data phase pending is legal
            ev_log = 1'b0;
         end
         else if (retry_en_reg)
         begin
            // Retry replaces the protocol error
            ev_log   = 1'b0;
            ev_retry = 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   logic bus_go;   // Valid address phase taken
   assign bus_go = i_hsel && i_hready && (i_htrans == NBEA_HTRANS_NONSEQ);

   // Write helper: is a pending write aimed at an offset
   function automatic logic wr_hit(input logic pend, input logic [7:0] a, input logic [7:0] ofs);
      return pend && (a == ofs);
   endfunction

   // Latches write address phase
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end
      else
      begin
         wr_pend_reg <= bus_go && i_hwrite;
         wr_addr_reg <= i_haddr;
      end
   end

   // ---------------------------------------------------------------
   // Error log, loaded on a logged event or by software write
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         addr_reg  <= NBEA_ADDR_RST;
         valid_reg <= 1'b0;
         address_valid_flag_reg <= 1'b0;
         prot_reg  <= 1'b0;
      end
      else if (ev_log)
      begin
         valid_reg <= 1'b1;
         address_valid_flag_reg <= i_event_addr_valid;
         prot_reg  <= ev_is_prot;
         addr_reg  <= NBEA_ADDR_RST;
         if (ev_is_prot)
         begin
            addr_reg[NBEA_RSN_LSB +: NBEA_RSN_W] <= ev_code;
            if (i_event_addr_valid)
            begin
               // Only the cache line address is kept
               addr_reg[NBEA_PA_W-1:NBEA_PROT_PA_LSB] <=
                  i_event_addr[NBEA_PA_W-1:NBEA_PROT_PA_LSB];
            end
         end
         else
         begin
            // Bit zero stays reserved as zero
            addr_reg[NBEA_PA_W-1:1] <= i_event_addr[NBEA_PA_W-1:1];
         end
      end
      else if (wr_hit(wr_pend_reg, wr_addr_reg, NBEA_ADDR_LO_OFS))
      begin
         addr_reg[31:1] <= i_hwdata[31:1];
      end
      else if (wr_hit(wr_pend_reg, wr_addr_reg, NBEA_ADDR_HI_OFS))
      begin
         addr_reg[47:32] <= i_hwdata[15:0];
      end
      else if (wr_hit(wr_pend_reg, wr_addr_reg, NBEA_STATUS_OFS))
      begin
         valid_reg <= i_hwdata[NBEA_ST_VALID];
         address_valid_flag_reg <= i_hwdata[NBEA_ST_ADDRESS_VALID_FLAG];
         prot_reg  <= i_hwdata[NBEA_ST_PROT];
      end
   end

   // Retry mode enable, software controlled
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
         retry_en_reg <= 1'b0;
      else if (wr_hit(wr_pend_reg, wr_addr_reg, NBEA_STATUS_OFS))
         retry_en_reg <= i_hwdata[NBEA_ST_RETRY];
   end

   // Link retry request pulse
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
         o_link_retry <= 1'b0;
      else
         o_link_retry <= ev_retry;
   end

   // ---------------------------------------------------------------
   // Interrupt status and mask
   // ---------------------------------------------------------------
   logic [NBEA_IRQ_W-1:0] irq_set;   // Events this cycle
   assign irq_set = {ev_retry, ev_log};

   // Sticky status; a new event wins over a clear
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
         irq_st_reg <= '0;
      else if (wr_hit(wr_pend_reg, wr_addr_reg, NBEA_IRQ_ST_OFS))
         irq_st_reg <= (irq_st_reg & ~i_hwdata[NBEA_IRQ_W-1:0]) | irq_set;
      else
         irq_st_reg <= irq_st_reg | irq_set;
   end

   // Mask register
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
         irq_msk_reg <= '0;
      else if (wr_hit(wr_pend_reg, wr_addr_reg, NBEA_IRQ_MSK_OFS))
         irq_msk_reg <= i_hwdata[NBEA_IRQ_W-1:0];
   end

   // Interrupt output, registered
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
         o_irq <= 1'b0;
      else
         o_irq <= |(irq_st_reg & irq_msk_reg);
   end

   // ---------------------------------------------------------------
   // Read data, prepared in the address phase
   // ---------------------------------------------------------------
   logic [31:0] rd_mux;   // Read value for current address
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      unique case (i_haddr)
         NBEA_ADDR_LO_OFS : rd_mux = {addr_reg[31:1], 1'b0};
         NBEA_ADDR_HI_OFS : rd_mux = {16'h0000, addr_reg[47:32]};
         NBEA_STATUS_OFS  : rd_mux = {28'h000_0000, retry_en_reg, prot_reg, address_valid_flag_reg, valid_reg};
         NBEA_IRQ_ST_OFS  : rd_mux = {30'h0000_0000, irq_st_reg};
         NBEA_IRQ_MSK_OFS : rd_mux = {30'h0000_0000, irq_msk_reg};
         default          : rd_mux = 32'h0000_0000;   // Unmapped reads zero
      endcase
   end

   // Read data register; zero-wait, always OKAY
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_hrdata    <= 32'h0000_0000;
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
      end
      else
      begin
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
         if (bus_go && !i_hwrite)
            o_hrdata <= rd_mux;
      end
   end
endmodule

//--- inc/nbea_pkg.sv
// Package with register map, field layout and reason codes of the error address encoder
package nbea_pkg;
   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] NBEA_ADDR_LO_OFS = 8'h00;  // Error address bits 31:0
   localparam logic [7:0] NBEA_ADDR_HI_OFS = 8'h04;  // Error address bits 47:32
   localparam logic [7:0] NBEA_STATUS_OFS  = 8'h08;  // Log status and mode control
   localparam logic [7:0] NBEA_IRQ_ST_OFS  = 8'h0C;  // Sticky event bits, write one to clear
   localparam logic [7:0] NBEA_IRQ_MSK_OFS = 8'h10;  // Interrupt mask, same layout

   // ---------------------------------------------------------------
   // Field layout
   // ---------------------------------------------------------------
   localparam int NBEA_PA_W       = 48;  // Physical address width
   localparam int NBEA_RSN_LSB    = 1;   // Reason code low bit
   localparam int NBEA_RSN_W      = 5;   // Reason code width
   localparam int NBEA_PROT_PA_LSB = 6;  // Lowest address bit kept for protocol errors
   localparam int NBEA_ST_VALID   = 0;   // Status: log holds an error
   localparam int NBEA_ST_ADDRESS_VALID_FLAG   = 1;   // Status: address valid flag
   localparam int NBEA_ST_PROT    = 2;   // Status: protocol format in use
   localparam int NBEA_ST_RETRY   = 3;   // Status: error-retry mode enable (RW)
   localparam int NBEA_IRQ_LOG    = 0;   // Event: protocol or address error logged
   localparam int NBEA_IRQ_RETRY  = 1;   // Event: link retry requested
   localparam int NBEA_IRQ_W      = 2;   // Number of event bits
   localparam logic [47:0] NBEA_ADDR_RST = 48'h0000_0000_0000;  // Log reset value

   // ---------------------------------------------------------------
   // Error event encoding on the input side
   // ---------------------------------------------------------------
   typedef enum logic [4:0]
   {
      NBEA_EV_NONE,          // No error
      NBEA_EV_DEFAULT,       // Address-valid error of default format
      NBEA_EV_RD_RSP,        // Read response without request
      NBEA_EV_PROBE_RSP,     // Probe response without request
      NBEA_EV_TGT_DONE,      // Unmatched target_done_response
      NBEA_EV_TGT_START,     // Unmatched target_start_response
      NBEA_EV_CMD_OVF,       // Link command buffer overflow
      NBEA_EV_DATA_OVF,      // Link data buffer overflow
      NBEA_EV_RETRY_OVF,     // Retry acknowledge counter overflow
      NBEA_EV_DATA_MID,      // Data command during data transfer
      NBEA_EV_ADDR_EXT,      // Address extension not followed by addressed command
      NBEA_EV_COH_TO_IO,     // Coherent-only packet toward IO link
      NBEA_EV_BAD_CMD,       // Invalid command
      NBEA_EV_CTRL_DROP,     // Control signal deasserted, no data phase
      NBEA_EV_L3_REQ_MULTI,  // Request multiple L3 hits
      NBEA_EV_L3_PRB_MULTI,  // Probe multiple L3 hits
      NBEA_EV_L3_RQ_OVF,     // L3 request queue overflow
      NBEA_EV_L3_WRVIC,      // Dirty victim incompatible state
      NBEA_EV_L3_CLVIC       // Clean victim incompatible state
   } nbea_event_t;

   // ---------------------------------------------------------------
   // Reason codes
   // ---------------------------------------------------------------
   localparam logic [4:0] NBEA_RC_RD_RSP    = 5'h00;
   localparam logic [4:0] NBEA_RC_PROBE_RSP = 5'h01;
   localparam logic [4:0] NBEA_RC_TGT_DONE  = 5'h02;
   localparam logic [4:0] NBEA_RC_TGT_START = 5'h03;
   localparam logic [4:0] NBEA_RC_CMD_OVF   = 5'h04;
   localparam logic [4:0] NBEA_RC_DATA_OVF  = 5'h05;
   localparam logic [4:0] NBEA_RC_RETRY_OVF = 5'h06;
   localparam logic [4:0] NBEA_RC_DATA_MID  = 5'h07;
   localparam logic [4:0] NBEA_RC_ADDR_EXT  = 5'h08;
   localparam logic [4:0] NBEA_RC_COH_TO_IO = 5'h09;
   localparam logic [4:0] NBEA_RC_BAD_CMD   = 5'h0A;
   localparam logic [4:0] NBEA_RC_CTRL_DROP = 5'h0B;
   localparam logic [4:0] NBEA_RC_L3_REQ    = 5'h10;
   localparam logic [4:0] NBEA_RC_L3_PRB    = 5'h11;
   localparam logic [4:0] NBEA_RC_L3_RQOVF  = 5'h12;
   localparam logic [4:0] NBEA_RC_L3_WRVIC  = 5'h13;
   localparam logic [4:0] NBEA_RC_L3_CLVIC  = 5'h14;

   // ---------------------------------------------------------------
   // AHB-Lite encodings
   // ---------------------------------------------------------------
   localparam logic [1:0] NBEA_HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] NBEA_HSIZE_WORD    = 3'h2;
endpackage

//--- verif/nbea_properties.sv
// Concurrent properties of the error address encoder, bound to its ports
`timescale 1ns/1ps
module nbea_checker
   import nbea_pkg::*;
(
   // Clock, reset and event side
   input  wire logic                  i_clock,
   input  wire logic                  i_reset_n,
   input  wire nbea_pkg::nbea_event_t i_event,
   input  wire logic                  i_event_addr_valid,
   input  wire logic [47:0]           i_event_addr,
   input  wire logic                  i_event_data_pending,
   input  wire logic                  o_link_retry,
   // Register bus and interrupt
   input  wire logic                  i_hsel,
   input  wire logic [7:0]            i_haddr,
   input  wire logic [1:0]            i_htrans,
   input  wire logic                  i_hwrite,
   input  wire logic                  i_hready,
   input  wire logic [31:0]           o_hrdata,
   input  wire logic                  o_hreadyout,
   input  wire logic                  o_hresp,
   input  wire logic                  o_irq
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);
   logic [47:0] addr_d1;  // Event address one cycle back
   logic [47:0] addr_d2;  // Event address two cycles back
   logic        xfer;     // Bus transfer taken at this edge
   assign xfer = i_hsel && i_hready && (i_htrans == NBEA_HTRANS_NONSEQ);
   // Delay line so the logged address can be compared at read-data time
   always_ff @(posedge i_clock or negedge i_reset_n)
      if (!i_reset_n)
         {addr_d2, addr_d1} <= 96'h0;
      else
         {addr_d2, addr_d1} <= {addr_d1, i_event_addr};
   // Read address phase with no event competing for the log
   sequence s_rd(a);
      xfer && !i_hwrite && (i_haddr == a) && (i_event == NBEA_EV_NONE);
   endsequence
   property p_okay;
      o_hreadyout && !o_hresp;
   endproperty
   a_okay: assert property (p_okay) else $error("bus answer not ready or not okay");
   property p_default;
      (i_event == NBEA_EV_DEFAULT) ##1 s_rd(NBEA_ADDR_LO_OFS) |-> ##1 (o_hrdata == {addr_d2[31:1], 1'b0});
   endproperty
   a_default: assert property (p_default) else $error("default log low word wrong");
   property p_rdrsp;
      (i_event == NBEA_EV_RD_RSP) ##1 s_rd(NBEA_ADDR_LO_OFS) |-> ##1 (o_hrdata[5:1] == 5'h00);
   endproperty
   a_rdrsp: assert property (p_rdrsp) else $error("read response code wrong");
   property p_done;
      (i_event == NBEA_EV_TGT_DONE) ##1 s_rd(NBEA_ADDR_LO_OFS) |-> ##1 (o_hrdata[5:1] == 5'h02);
   endproperty
   a_done: assert property (p_done) else $error("target done code wrong");
   property p_rqovf;
      (i_event == NBEA_EV_L3_RQ_OVF) ##1 s_rd(NBEA_ADDR_LO_OFS) |-> ##1 (o_hrdata[5:1] == 5'h12);
   endproperty
   a_rqovf: assert property (p_rqovf) else $error("queue overflow code wrong");
   property p_noaddr;
      (i_event == NBEA_EV_TGT_DONE && !i_event_addr_valid) ##1 s_rd(NBEA_ADDR_LO_OFS) |-> ##1 (o_hrdata[31:6] == 26'h0);
   endproperty
   a_noaddr: assert property (p_noaddr) else $error("address kept without valid flag");
   property p_retry_src;
      o_link_retry |-> ($past(i_event) == NBEA_EV_CTRL_DROP) && !$past(i_event_data_pending);
   endproperty
   a_retry_src: assert property (p_retry_src) else $error("retry without control drop");
   property p_pend;
      (i_event == NBEA_EV_CTRL_DROP) && i_event_data_pending |=> !o_link_retry;
   endproperty
   a_pend: assert property (p_pend) else $error("retry while data pending");
   property p_quiet;
      (!xfer && (i_event == NBEA_EV_NONE)) [*3] |=> $stable(o_irq);
   endproperty
   a_quiet: assert property (p_quiet) else $error("interrupt moved with no cause");
endmodule
bind nbea_encoder nbea_checker u_chk (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_event(i_event),
   .i_event_addr_valid(i_event_addr_valid), .i_event_addr(i_event_addr),
   .i_event_data_pending(i_event_data_pending), .o_link_retry(o_link_retry), .i_hsel(i_hsel),
   .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready),
   .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_irq(o_irq));

//--- verif/tb_top.sv
// Self-checking testbench of the error address encoder
`timescale 1ns/1ps
module tb_top;
   import nbea_pkg::*;
   // ---------------------------------------------------------------
   // Design signals and counters
   // ---------------------------------------------------------------
   logic        i_clock = 1'b0, i_reset_n = 1'b0, i_hsel = 1'b0, i_hwrite = 1'b0;
   logic        i_event_addr_valid = 1'b0, i_event_retry_mode = 1'b0;
   logic        i_event_crc_ok = 1'b1, i_event_data_pending = 1'b0;
   nbea_event_t i_event = NBEA_EV_NONE;
   logic [47:0] i_event_addr = 48'h0;
   logic [7:0]  i_haddr = 8'h00;
   logic [1:0]  i_htrans = 2'h0;
   logic [2:0]  i_hsize = NBEA_HSIZE_WORD;
   logic [31:0] i_hwdata = 32'h0, o_hrdata, rd;
   logic        o_link_retry, o_hreadyout, o_hresp, o_irq;
   int          mismatches = 0, compares = 0;
   localparam logic [47:0] ADR = 48'hA5C3_1234_5679;  // Odd so the reserved bit is exercised
   nbea_encoder u_dut (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_event(i_event),
      .i_event_addr_valid(i_event_addr_valid), .i_event_addr(i_event_addr),
      .i_event_retry_mode(i_event_retry_mode), .i_event_crc_ok(i_event_crc_ok),
      .i_event_data_pending(i_event_data_pending), .o_link_retry(o_link_retry), .i_hsel(i_hsel),
      .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize),
      .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hrdata(o_hrdata),
      .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_irq(o_irq));
   always #2 i_clock = ~i_clock;
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic complete_run();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Compare one value and count it
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Bounded wait for the slave to be ready at a rising edge
   task automatic wait_rdy();
      int n;
      n = 0;
      do
      begin
         @(posedge i_clock);
         n++;
      end
      while (o_hreadyout !== 1'b1 && n < 16);
      if (o_hreadyout !== 1'b1)
      begin
         mismatches++;
         $display("BAD at %0t: bus hung", $time);
         complete_run();
      end
   endtask
   // One single-word transfer; also ends any pending event pulse
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clock);
      i_event <= NBEA_EV_NONE;
      i_hsel <= 1'b1;
      i_htrans <= NBEA_HTRANS_NONSEQ;
      i_haddr <= a;
      i_hwrite <= wr;
      wait_rdy();
      i_htrans <= 2'h0;
      i_hwdata <= d;
      wait_rdy();
      rd = o_hrdata;
   endtask
   // One-cycle event pulse with its qualifiers
   task automatic ev(input nbea_event_t e, input logic av, input logic rm, input logic crc, input logic dp);
      @(posedge i_clock);
      i_event <= e;
      i_event_addr_valid <= av;
      i_event_addr <= ADR;
      i_event_retry_mode <= rm;
      i_event_crc_ok <= crc;
      i_event_data_pending <= dp;
   endtask
   // Read both log words and compare
   task automatic chklog(input logic [31:0] lo, input logic [31:0] hi);
      bus(1'b0, NBEA_ADDR_LO_OFS, 32'h0);
      chk(rd, lo);
      bus(1'b0, NBEA_ADDR_HI_OFS, 32'h0);
      chk(rd, hi);
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      logic [7:0] ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
      foreach (ofs[i])
      begin
         bus(1'b0, ofs[i], 32'h0);
         chk(rd, 32'h0);
      end
      $display("reset values test done");
   endtask
   task automatic t_default();
      ev(NBEA_EV_DEFAULT, 1'b1, 1'b0, 1'b1, 1'b0);
      chklog({ADR[31:1], 1'b0}, {16'h0, ADR[47:32]});
      bus(1'b0, NBEA_STATUS_OFS, 32'h0);
      chk(rd, 32'h3);
      $display("default format test done");
   endtask
   task automatic t_codes();
      nbea_event_t e [17] = '{NBEA_EV_RD_RSP, NBEA_EV_PROBE_RSP, NBEA_EV_TGT_DONE, NBEA_EV_TGT_START,
         NBEA_EV_CMD_OVF, NBEA_EV_DATA_OVF, NBEA_EV_RETRY_OVF, NBEA_EV_DATA_MID, NBEA_EV_ADDR_EXT,
         NBEA_EV_COH_TO_IO, NBEA_EV_BAD_CMD, NBEA_EV_CTRL_DROP, NBEA_EV_L3_REQ_MULTI,
         NBEA_EV_L3_PRB_MULTI, NBEA_EV_L3_RQ_OVF, NBEA_EV_L3_WRVIC, NBEA_EV_L3_CLVIC};
      logic [4:0] c [17] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
         5'h0A, 5'h0B, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14};
      logic av;
      foreach (e[i])
      begin
         av = 1'(i % 2);
         ev(e[i], av, 1'b0, 1'b1, 1'b0);
         chklog({av ? ADR[31:6] : 26'h0, c[i], 1'b0}, {16'h0, av ? ADR[47:32] : 16'h0});
         bus(1'b0, NBEA_STATUS_OFS, 32'h0);
         chk(rd, {29'h0, 1'b1, av, 1'b1});
      end
      $display("reason code test done");
   endtask
   task automatic t_retry();
      ev(NBEA_EV_TGT_DONE, 1'b1, 1'b1, 1'b0, 1'b0);
      ev(NBEA_EV_BAD_CMD, 1'b1, 1'b1, 1'b0, 1'b0);
      chklog({ADR[31:6], 5'h02, 1'b0}, {16'h0, ADR[47:32]});
      ev(NBEA_EV_BAD_CMD, 1'b1, 1'b1, 1'b1, 1'b0);
      chklog({ADR[31:6], 5'h0A, 1'b0}, {16'h0, ADR[47:32]});
      ev(NBEA_EV_TGT_DONE, 1'b1, 1'b0, 1'b1, 1'b0);
      ev(NBEA_EV_CTRL_DROP, 1'b1, 1'b0, 1'b1, 1'b1);
      chklog({ADR[31:6], 5'h02, 1'b0}, {16'h0, ADR[47:32]});
      bus(1'b1, NBEA_IRQ_ST_OFS, 32'h3);
      bus(1'b1, NBEA_STATUS_OFS, 32'h8);
      ev(NBEA_EV_CTRL_DROP, 1'b1, 1'b0, 1'b1, 1'b0);
      @(posedge i_clock);
      i_event <= NBEA_EV_NONE;
      #1 chk({31'h0, o_link_retry}, 32'h1);
      chklog({ADR[31:6], 5'h02, 1'b0}, {16'h0, ADR[47:32]});
      bus(1'b0, NBEA_IRQ_ST_OFS, 32'h0);
      chk(rd, 32'h2);
      $display("retry mode test done");
   endtask
   task automatic t_irq();
      bus(1'b1, NBEA_IRQ_ST_OFS, 32'h3);
      ev(NBEA_EV_PROBE_RSP, 1'b0, 1'b0, 1'b1, 1'b0);
      bus(1'b0, NBEA_IRQ_ST_OFS, 32'h0);
      chk(rd, 32'h1);
      chk({31'h0, o_irq}, 32'h0);
      bus(1'b1, NBEA_IRQ_MSK_OFS, 32'h1);
      @(posedge i_clock);
      #1 chk({31'h0, o_irq}, 32'h1);
      bus(1'b1, NBEA_IRQ_ST_OFS, 32'h1);
      @(posedge i_clock);
      #1 chk({31'h0, o_irq}, 32'h0);
      $display("interrupt test done");
   endtask
   initial
   begin
      repeat (4) @(posedge i_clock);
      i_reset_n <= 1'b1;
      t_reset();
      t_default();
      t_codes();
      t_retry();
      t_irq();
      complete_run();
   end
endmodule
